// file: src/pdeo_regs.vh
`ifndef PDEO_REGS_VH
`define PDEO_REGS_VH
`define PDEO_CLK_PERIOD_PS 4000
`define PDEO_SPIKE_MIN_NS 50
`define PDEO_SPIKE_CYCLES ((`PDEO_SPIKE_MIN_NS * 1000 + `PDEO_CLK_PERIOD_PS - 1) / `PDEO_CLK_PERIOD_PS)
`define PDEO_BIT_TWI_SCL 0
`define PDEO_BIT_TWI_SDA 1
`define PDEO_BIT_RXD 2
`define PDEO_BIT_TXD 3
`define PDEO_BIT_TIMER1_CAPTURE_INPUT 4
`define PDEO_BIT_SERIAL1_SYNC_CLOCK 5
`define PDEO_BIT_SERIAL0_SYNC_CLOCK 2
`define PDEO_BIT_OCA 3
`define PDEO_BIT_OCB 4
`define PDEO_BIT_OCC 5
`define PDEO_BIT_T3 6
`define PDEO_BIT_DIVIDED_CLOCK_OUTPUT 7
`endif

// file: src/pdeo_spike_filter.v
`timescale 1ns/1ps
`include "pdeo_regs.vh"
module pdeo_spike_filter #(
  parameter CYCLES = `PDEO_SPIKE_CYCLES
) (
  clk,
  rst,
  din,
  dout
);
  input wire clk;
  input wire rst;
  input wire din;
  output reg dout;
  reg [7:0] cnt_q;
  // output follows only after the input held a new level for CYCLES clocks
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
      dout <= 1'b1;
    end else if (din == dout) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= CYCLES[7:0] - 8'h01) begin
      cnt_q <= 8'h00;
      dout <= din;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

// file: src/pdeo_pin_override.v
`timescale 1ns/1ps
`include "pdeo_regs.vh"
// Contract
// - transmitter enabled: pd3 output, no pull-up, driven by transmit line
// - receiver enabled: pd2 forced input, value fed to receiver
// - forced-input pd2 pull-up follows its port bit unless pull-ups globally disabled
// - two-wire enable hands pd1 to interface as data line
// - two-wire enable hands pd0 to interface as clock line
// - two-wire line inputs filtered, pulses under 50 ns rejected
// - two-wire lines open drain: value 0, direction from drive-low request, gated pull-up
// - pd4 input routed to timer1 capture, pin settings untouched
// - pd3..pd0 interrupt enable forces input path on, pin value to interrupt
// - pe2 carries serial0 sync clock in sync mode; direction bit picks in/out
// - clock-out fuse drives divided clock on pe7 over port and direction
// - divided clock stays on pe7 during reset when fuse programmed
// - enabled timer3 compare drives pin value instead of port bit
// - pe7 input feeds interrupt 7 and timer3 capture
// - pe6 input feeds timer3 count source and interrupt 6
// - pe7..pe4 interrupt enable forces input path on, no other override
// - pd5 carries serial1 sync clock in sync mode; direction bit picks in/out
module pdeo_pin_override (
  clk,
  rst,
  global_pullup_disable,
  portd_out,
  portd_dir,
  porte_out,
  porte_dir,
  portd_pin_in,
  porte_pin_in,
  serial1_transmit_enable,
  serial1_transmit_line,
  serial1_receive_enable,
  serial1_sync_mode,
  serial1_sync_clock_out,
  serial0_sync_mode,
  serial0_sync_clock_out,
  two_wire_enable,
  two_wire_sda_drive_low,
  two_wire_scl_drive_low,
  ext_irq_enable,
  timer3_compare_en,
  timer3_compare_out_a,
  timer3_compare_out_b,
  timer3_compare_out_c,
  clock_output_fuse,
  divided_clock_output,
  portd_pullup,
  portd_oe,
  portd_value,
  portd_in_enable,
  porte_pullup,
  porte_oe,
  porte_value,
  porte_in_enable,
  serial1_receive_line,
  serial1_sync_clock_in,
  serial0_sync_clock_in,
  two_wire_sda_in,
  two_wire_scl_in,
  timer1_capture_input,
  timer3_capture_input,
  timer3_count_input,
  ext_irq_lines
);
  input wire clk;
  input wire rst;
  input wire global_pullup_disable;
  input wire [7:0] portd_out;
  input wire [7:0] portd_dir;
  input wire [7:0] porte_out;
  input wire [7:0] porte_dir;
  input wire [7:0] portd_pin_in;
  input wire [7:0] porte_pin_in;
  input wire serial1_transmit_enable;
  input wire serial1_transmit_line;
  input wire serial1_receive_enable;
  input wire serial1_sync_mode;
  input wire serial1_sync_clock_out;
  input wire serial0_sync_mode;
  input wire serial0_sync_clock_out;
  input wire two_wire_enable;
  input wire two_wire_sda_drive_low;
  input wire two_wire_scl_drive_low;
  input wire [7:0] ext_irq_enable;
  input wire [2:0] timer3_compare_en;
  input wire timer3_compare_out_a;
  input wire timer3_compare_out_b;
  input wire timer3_compare_out_c;
  input wire clock_output_fuse;
  input wire divided_clock_output;
  output reg [7:0] portd_pullup;
  output reg [7:0] portd_oe;
  output reg [7:0] portd_value;
  output reg [7:0] portd_in_enable;
  output reg [7:0] porte_pullup;
  output reg [7:0] porte_oe;
  output reg [7:0] porte_value;
  output reg [7:0] porte_in_enable;
  output reg serial1_receive_line;
  output reg serial1_sync_clock_in;
  output reg serial0_sync_clock_in;
  output reg two_wire_sda_in;
  output reg two_wire_scl_in;
  output reg timer1_capture_input;
  output reg timer3_capture_input;
  output reg timer3_count_input;
  output reg [7:0] ext_irq_lines;

  // per-pin override enables and values, portd in [7:0], porte in [15:8]
  reg [15:0] puoe;
  reg [15:0] puov;
  reg [15:0] ddoe;
  reg [15:0] ddov;
  reg [15:0] pvoe;
  reg [15:0] pvov;
  reg [15:0] dieoe;
  wire [15:0] port_out;
  wire [15:0] port_dir;
  wire [15:0] pu_d;
  wire [15:0] oe_d;
  wire [15:0] val_d;
  wire [15:0] ie_d;
  wire serial1_sync_clock_out_en;
  wire serial0_sync_clock_out_en;
  wire sda_filt;
  wire scl_filt;

  assign port_out = {porte_out, portd_out};
  assign port_dir = {porte_dir, portd_dir};
  assign serial1_sync_clock_out_en = serial1_sync_mode & portd_dir[`PDEO_BIT_SERIAL1_SYNC_CLOCK];
  assign serial0_sync_clock_out_en = serial0_sync_mode & porte_dir[`PDEO_BIT_SERIAL0_SYNC_CLOCK];

  always @* begin
    puoe = 16'h0000;
    puov = 16'h0000;
    ddoe = 16'h0000;
    ddov = 16'h0000;
    pvoe = 16'h0000;
    pvov = 16'h0000;
    dieoe = {4'h0, ext_irq_enable[7:4], 4'h0, ext_irq_enable[3:0]};
    if (serial1_transmit_enable) begin
      puoe[`PDEO_BIT_TXD] = 1'b1;
      ddoe[`PDEO_BIT_TXD] = 1'b1;
      ddov[`PDEO_BIT_TXD] = 1'b1;
      pvoe[`PDEO_BIT_TXD] = 1'b1;
      pvov[`PDEO_BIT_TXD] = serial1_transmit_line;
    end
    if (serial1_receive_enable) begin
      puoe[`PDEO_BIT_RXD] = 1'b1;
      puov[`PDEO_BIT_RXD] = portd_out[`PDEO_BIT_RXD] & ~global_pullup_disable;
      ddoe[`PDEO_BIT_RXD] = 1'b1;
    end
    if (two_wire_enable) begin
      puoe[1:0] = 2'h3;
      puov[1:0] = portd_out[1:0] & {2{~global_pullup_disable}};
      ddoe[1:0] = 2'h3;
      ddov[1:0] = {two_wire_sda_drive_low, two_wire_scl_drive_low};
      pvoe[1:0] = 2'h3;
    end
    if (serial1_sync_clock_out_en) begin
      ddoe[`PDEO_BIT_SERIAL1_SYNC_CLOCK] = 1'b1;
      ddov[`PDEO_BIT_SERIAL1_SYNC_CLOCK] = 1'b1;
      pvoe[`PDEO_BIT_SERIAL1_SYNC_CLOCK] = 1'b1;
      pvov[`PDEO_BIT_SERIAL1_SYNC_CLOCK] = serial1_sync_clock_out;
    end
    if (serial0_sync_clock_out_en) begin
      ddoe[8 + `PDEO_BIT_SERIAL0_SYNC_CLOCK] = 1'b1;
      ddov[8 + `PDEO_BIT_SERIAL0_SYNC_CLOCK] = 1'b1;
      pvoe[8 + `PDEO_BIT_SERIAL0_SYNC_CLOCK] = 1'b1;
      pvov[8 + `PDEO_BIT_SERIAL0_SYNC_CLOCK] = serial0_sync_clock_out;
    end
    // direction stays with software; the pin shows the wave only if set
    pvoe[8 + `PDEO_BIT_OCA] = timer3_compare_en[0];
    pvov[8 + `PDEO_BIT_OCA] = timer3_compare_out_a;
    pvoe[8 + `PDEO_BIT_OCB] = timer3_compare_en[1];
    pvov[8 + `PDEO_BIT_OCB] = timer3_compare_out_b;
    pvoe[8 + `PDEO_BIT_OCC] = timer3_compare_en[2];
    pvov[8 + `PDEO_BIT_OCC] = timer3_compare_out_c;
    if (clock_output_fuse) begin
      ddoe[8 + `PDEO_BIT_DIVIDED_CLOCK_OUTPUT] = 1'b1;
      ddov[8 + `PDEO_BIT_DIVIDED_CLOCK_OUTPUT] = 1'b1;
      pvoe[8 + `PDEO_BIT_DIVIDED_CLOCK_OUTPUT] = 1'b1;
      pvov[8 + `PDEO_BIT_DIVIDED_CLOCK_OUTPUT] = divided_clock_output;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_pin
      assign pu_d[i] = puoe[i] ? puov[i] :
        (port_out[i] & ~port_dir[i] & ~global_pullup_disable);
      assign oe_d[i] = ddoe[i] ? ddov[i] : port_dir[i];
      assign val_d[i] = pvoe[i] ? pvov[i] : port_out[i];
      assign ie_d[i] = dieoe[i] | 1'b1; // input path always on, whatever the interrupt enables
    end
  endgenerate

  pdeo_spike_filter u_sda_filt (
    .clk(clk),
    .rst(rst),
    .din(portd_pin_in[`PDEO_BIT_TWI_SDA]),
    .dout(sda_filt)
  );

  pdeo_spike_filter u_scl_filt (
    .clk(clk),
    .rst(rst),
    .din(portd_pin_in[`PDEO_BIT_TWI_SCL]),
    .dout(scl_filt)
  );

  always @(posedge clk) begin
    if (rst) begin
      portd_pullup <= 8'h00;
      portd_oe <= 8'h00;
      portd_value <= 8'h00;
      portd_in_enable <= 8'h00;
      porte_pullup <= 8'h00;
      porte_oe <= 8'h00;
      porte_value <= 8'h00;
      porte_in_enable <= 8'h00;
      serial1_receive_line <= 1'b1;
      serial1_sync_clock_in <= 1'b0;
      serial0_sync_clock_in <= 1'b0;
      two_wire_sda_in <= 1'b1;
      two_wire_scl_in <= 1'b1;
      timer1_capture_input <= 1'b0;
      timer3_capture_input <= 1'b0;
      timer3_count_input <= 1'b0;
      ext_irq_lines <= 8'h00;
      // divided clock is not silenced by reset
      if (clock_output_fuse) begin
        porte_oe[`PDEO_BIT_DIVIDED_CLOCK_OUTPUT] <= 1'b1;
        porte_value[`PDEO_BIT_DIVIDED_CLOCK_OUTPUT] <= divided_clock_output;
      end
    end else begin
      portd_pullup <= pu_d[7:0];
      portd_oe <= oe_d[7:0];
      portd_value <= val_d[7:0];
      portd_in_enable <= ie_d[7:0];
      porte_pullup <= pu_d[15:8];
      porte_oe <= oe_d[15:8];
      porte_value <= val_d[15:8];
      porte_in_enable <= ie_d[15:8];
      serial1_receive_line <= portd_pin_in[`PDEO_BIT_RXD];
      serial1_sync_clock_in <= serial1_sync_mode & portd_pin_in[`PDEO_BIT_SERIAL1_SYNC_CLOCK];
      serial0_sync_clock_in <= serial0_sync_mode & porte_pin_in[`PDEO_BIT_SERIAL0_SYNC_CLOCK];
      two_wire_sda_in <= two_wire_enable ? sda_filt : 1'b1;
      two_wire_scl_in <= two_wire_enable ? scl_filt : 1'b1;
      timer1_capture_input <= portd_pin_in[`PDEO_BIT_TIMER1_CAPTURE_INPUT];
      timer3_capture_input <= porte_pin_in[`PDEO_BIT_DIVIDED_CLOCK_OUTPUT];
      timer3_count_input <= porte_pin_in[`PDEO_BIT_T3];
      ext_irq_lines <= {porte_pin_in[7:4], portd_pin_in[3:0]} & ext_irq_enable;
    end
  end
endmodule

// file: dv/pdeo_periph_model.sv
`timescale 1ns/1ps
module pdeo_periph_model (
  input logic clk,
  output logic divided_clock_output,
  output logic timer3_compare_out_a,
  output logic timer3_compare_out_b,
  output logic timer3_compare_out_c
);
  // divider is not reset, so the clock pin keeps toggling while reset is held
  logic [3:0] cnt_q = 4'h0;
  always @(posedge clk) cnt_q <= cnt_q + 4'h1;
  assign divided_clock_output = cnt_q[0];
  assign timer3_compare_out_a = cnt_q[1];
  assign timer3_compare_out_b = cnt_q[2];
  assign timer3_compare_out_c = cnt_q[3];
endmodule

// file: dv/pdeo_pin_override_sva.sv
`timescale 1ns/1ps
module pdeo_pin_override_chk (
  input logic clk, rst, global_pullup_disable, serial1_transmit_enable,
  input logic serial1_transmit_line, serial1_receive_enable, serial1_receive_line,
  input logic two_wire_enable, two_wire_sda_drive_low, two_wire_scl_drive_low,
  input logic serial0_sync_mode, serial0_sync_clock_out, serial1_sync_mode,
  input logic serial1_sync_clock_out, timer3_compare_out_a, clock_output_fuse,
  input logic divided_clock_output, timer1_capture_input, timer3_capture_input,
  input logic timer3_count_input,
  input logic [2:0] timer3_compare_en,
  input logic [7:0] portd_out, portd_dir, portd_pin_in, porte_pin_in, porte_dir,
  input logic [7:0] ext_irq_enable, ext_irq_lines,
  input logic [7:0] portd_oe, portd_pullup, portd_value, porte_oe, porte_value
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  tx_pin_drive_a:
    assert property (serial1_transmit_enable |=> portd_oe[3] && !portd_pullup[3]
      && portd_value[3] == $past(serial1_transmit_line)) else $error("tx pin not driven");
  rx_pin_input_a:
    assert property (serial1_receive_enable |=> !portd_oe[2]
      && serial1_receive_line == $past(portd_pin_in[2])
      && portd_pullup[2] == ($past(portd_out[2]) && !$past(global_pullup_disable)))
      else $error("rx pin wrong");
  twi_open_drain_a:
    assert property (two_wire_enable |=> portd_value[1:0] == 2'h0
      && portd_oe[1:0] == $past({two_wire_sda_drive_low, two_wire_scl_drive_low}))
      else $error("two-wire pins not open drain");
  capture_route_a:
    assert property (1'b1 |=> {timer1_capture_input, timer3_capture_input, timer3_count_input}
      == $past({portd_pin_in[4], porte_pin_in[7:6]})) else $error("timer input wrong");
  irq_route_a:
    assert property (1'b1 |=> ext_irq_lines
      == $past({porte_pin_in[7:4], portd_pin_in[3:0]} & ext_irq_enable)) else $error("irq wrong");
  serial0_sync_clock_out_a:
    assert property (serial0_sync_mode && porte_dir[2] |=> porte_oe[2]
      && porte_value[2] == $past(serial0_sync_clock_out)) else $error("sync clock 0 wrong");
  serial1_sync_clock_out_a:
    assert property (serial1_sync_mode && portd_dir[5] |=> portd_oe[5]
      && portd_value[5] == $past(serial1_sync_clock_out)) else $error("sync clock 1 wrong");
  clk_out_a:
    assert property (clock_output_fuse |=> porte_oe[7]
      && porte_value[7] == $past(divided_clock_output)) else $error("clock out missing");
  clk_out_reset_a:
    assert property (disable iff (1'b0) rst && clock_output_fuse |=> porte_oe[7]
      && porte_value[7] == $past(divided_clock_output)) else $error("clock out lost in reset");
  compare_a_value_a:
    assert property (timer3_compare_en[0] |=> porte_value[3] == $past(timer3_compare_out_a))
      else $error("compare a not on pin");
  port_dir_default_a:
    assert property (!serial1_transmit_enable |=> portd_oe[3] == $past(portd_dir[3]))
      else $error("port direction not used");
endmodule
bind pdeo_pin_override pdeo_pin_override_chk pdeo_pin_override_chk_inst (.*);

// file: dv/test_port_d_e_alt_function_override.sv
`timescale 1ns/1ps
`include "pdeo_regs.vh"
module test_port_d_e_alt_function_override;
  logic clk, rst, global_pullup_disable, serial1_transmit_enable, serial1_transmit_line;
  logic serial1_receive_enable, serial1_sync_mode, serial1_sync_clock_out, serial0_sync_mode;
  logic serial0_sync_clock_out, two_wire_enable, two_wire_sda_drive_low, two_wire_scl_drive_low;
  logic clock_output_fuse, divided_clock_output, timer3_compare_out_a, timer3_compare_out_b;
  logic timer3_compare_out_c, serial1_receive_line, serial1_sync_clock_in, serial0_sync_clock_in;
  logic two_wire_sda_in, two_wire_scl_in, timer1_capture_input, timer3_capture_input;
  logic timer3_count_input, lo;
  logic [2:0] timer3_compare_en;
  logic [7:0] portd_out, portd_dir, porte_out, porte_dir, portd_pin_in, porte_pin_in;
  logic [7:0] ext_irq_enable, portd_pullup, portd_oe, portd_value, portd_in_enable;
  logic [7:0] porte_pullup, porte_oe, porte_value, porte_in_enable, ext_irq_lines, e_oe;
  logic [15:0] d_exp;
  logic [23:0] v_exp;
  logic [7:0] irq_exp, sck_exp;
  logic [31:0] r;
  integer seed = 32'h746b2763, bad_count = 0, check_count = 0, cyc = 0, i;
  pdeo_pin_override pdeo_pin_override_inst (.*);
  pdeo_periph_model pdeo_periph_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      bad_count = bad_count + 1;
      close_out;
    end
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task rnd;
    r = $random(seed);
    {global_pullup_disable, serial1_transmit_enable, serial1_transmit_line,
      serial1_receive_enable, serial1_sync_mode, serial1_sync_clock_out, serial0_sync_mode,
      serial0_sync_clock_out, two_wire_enable, two_wire_sda_drive_low, two_wire_scl_drive_low,
      clock_output_fuse, timer3_compare_en} = r[14:0];
    {portd_out, portd_dir, porte_out, porte_dir} = $random(seed);
    r = $random(seed);
    {portd_pin_in, porte_pin_in, ext_irq_enable} = r[23:0];
  endtask
  // pull-ups off for output pins except the two-wire pins and the forced-input rx pin, so a forced tx output must lose its pull-up
  function automatic logic [15:0] exp_d();
    logic [7:0] oe, pu;
    oe = portd_dir;
    pu = portd_out & ~portd_dir & {8{!global_pullup_disable}};
    if (serial1_transmit_enable) {oe[3], pu[3]} = 2'h2;
    if (serial1_receive_enable) {oe[2], pu[2]} = {1'b0, portd_out[2] & !global_pullup_disable};
    if (two_wire_enable) begin
      oe[1:0] = {two_wire_sda_drive_low, two_wire_scl_drive_low};
      pu[1:0] = portd_out[1:0] & {2{!global_pullup_disable}};
    end
    exp_d = {pu, oe};
  endfunction
  // pin values and port e pull-ups, worked out from the override table
  function automatic logic [23:0] exp_v();
    logic [7:0] dv, ev, epu;
    dv = portd_out;
    ev = porte_out;
    epu = porte_out & ~porte_dir & {8{!global_pullup_disable}};
    if (serial1_transmit_enable) dv[3] = serial1_transmit_line;
    if (two_wire_enable) dv[1:0] = 2'h0;
    if (serial1_sync_mode && portd_dir[5]) dv[5] = serial1_sync_clock_out;
    if (serial0_sync_mode && porte_dir[2]) ev[2] = serial0_sync_clock_out;
    if (timer3_compare_en[0]) ev[3] = timer3_compare_out_a;
    if (timer3_compare_en[1]) ev[4] = timer3_compare_out_b;
    if (timer3_compare_en[2]) ev[5] = timer3_compare_out_c;
    if (clock_output_fuse) ev[7] = divided_clock_output;
    exp_v = {epu, ev, dv};
  endfunction
  initial begin
    rst = 1'b1;
    lo = 1'b0;
    rnd;
    clock_output_fuse = 1'b1;
    repeat (8) @(negedge clk);
    for (i = 0; i < 300; i = i + 1) begin
      rnd;
      rst = (i >= 150 && i < 153);
      if (rst) clock_output_fuse = 1'b1;
      d_exp = exp_d();
      e_oe = porte_dir | {clock_output_fuse, 7'h0};
      v_exp = exp_v();
      irq_exp = {porte_pin_in[7:4], portd_pin_in[3:0]} & ext_irq_enable;
      sck_exp = {6'h0, serial1_sync_mode & portd_pin_in[5], serial0_sync_mode & porte_pin_in[2]};
      @(negedge clk);
      if (!rst) begin
        chk("portd_value", v_exp[7:0], portd_value);
        chk("porte_value", v_exp[15:8], porte_value);
        chk("porte_pullup", v_exp[23:16], porte_pullup);
        chk("ext_irq_lines", irq_exp, ext_irq_lines);
        chk("sync_clock_in", sck_exp, {6'h0, serial1_sync_clock_in, serial0_sync_clock_in});
        chk("portd_oe", d_exp[7:0], portd_oe);
        chk("portd_pullup", d_exp[15:8], portd_pullup);
        chk("porte_oe", e_oe, porte_oe);
      end
    end
    rst = 1'b0;
    $display("random test done");
    two_wire_enable = 1'b1;
    portd_pin_in = 8'hFF;
    porte_dir = 8'h38;
    timer3_compare_en = 3'h7;
    repeat (`PDEO_SPIKE_CYCLES + 4) @(negedge clk);
    for (i = 0; i < 40; i = i + 1) begin
      portd_pin_in[1] = !(i < `PDEO_SPIKE_CYCLES - 1);
      @(negedge clk);
      lo = lo | !two_wire_sda_in;
    end
    chk("sda_spike", 8'h00, {7'h0, lo});
    portd_pin_in[1:0] = 2'h0;
    repeat (`PDEO_SPIKE_CYCLES + 4) @(negedge clk);
    chk("twi_lines", 8'h00, {6'h0, two_wire_sda_in, two_wire_scl_in});
    $display("filter test done");
    close_out;
  end
endmodule
